// *** design/temp_config_defines.vh ***
// Functional notes
// R1 - Config register 16 bits, upper byte used
// R2 - Reset loads upper nonvolatile config byte
// R3 - Copy command stores config and limits; the code stores only the config byte, on nv_config_store_out
// R4 - One-shot in shutdown converts once, clears
// R5 - One-shot ignored outside shutdown, reads zero
// R6 - Bits 14:13 select 9 to 12 bits
// R7 - Conversion time 25/50/100/200 ms by resolution
// R8 - Bits 12:11 select 1/2/4/6 faults
// R9 - Bit 10 sets alert polarity
// R10 - Bit 9 selects comparator or interrupt
// R11 - Bit 8 enters shutdown
// R12 - Bits 7:1 read as zero
// R13 - Bit 0 reads nonvolatile busy
// R14 - Address then pointer 01h, both acknowledged
// R15 - Only first data byte is taken
// R16 - Partial byte before stop/start discarded
// R17 - Locked: write ignored but acknowledged
// R18 - Accepted update clears fault counter
// R19 - Bus writes only config bits 15:8
`ifndef TEMP_CONFIG_DEFINES_VH
`define TEMP_CONFIG_DEFINES_VH

// ****************************************
// Bus addressing
// ****************************************
`define DEV_ADDR_HI   4'h9
`define CFG_PTR       8'h01
`define BIT_LAST      3'h7

// ****************************************
// Upper byte field positions
// ****************************************
`define OS_POS        7
`define RES_HI        6
`define RES_LO        5
`define FT_HI         4
`define FT_LO         3
`define POL_POS       2
`define MODE_POS      1
`define SD_POS        0
`define RSVD_VAL      7'h00

// ****************************************
// Conversion timing
// ****************************************
`define SYS_CLK_KHZ   20000
`define CONV_9_MS     25
`define CONV_10_MS    50
`define CONV_11_MS    100
`define CONV_12_MS    200
`define CONV_CNT_W    22

// ****************************************
// Fault queue
// ****************************************
`define FAULT_CNT_W   3
`define FQ_1          3'h1
`define FQ_2          3'h2
`define FQ_4          3'h4
`define FQ_6          3'h6

`endif

// *** design/pin_sync.v ***
module pin_sync #(
	parameter WIDTH = 5
) (
	input  wire             sys_clk_in,
	input  wire             resetn_in,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// Idle bus level is high, so settle to ones
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			meta_q <= {WIDTH{1'b1}};
			sync_q <= {WIDTH{1'b1}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // pin_sync

// *** design/conv_timer.v ***
`include "temp_config_defines.vh"
module conv_timer #(
	parameter [`CONV_CNT_W-1:0] CYC_9  = 22'h1,
	parameter [`CONV_CNT_W-1:0] CYC_10 = 22'h1,
	parameter [`CONV_CNT_W-1:0] CYC_11 = 22'h1,
	parameter [`CONV_CNT_W-1:0] CYC_12 = 22'h1
) (
	input  wire       sys_clk_in,
	input  wire       resetn_in,
	input  wire       run_in,
	input  wire [1:0] res_in,
	output reg        busy_out,
	output reg        done_out
);
	reg [`CONV_CNT_W-1:0] cnt_q;

	function [`CONV_CNT_W-1:0] conv_cycles;
		input [1:0] res;
		begin
			case (res)
				2'h0:    conv_cycles = CYC_9;
				2'h1:    conv_cycles = CYC_10;
				2'h2:    conv_cycles = CYC_11;
				default: conv_cycles = CYC_12;
			endcase
		end
	endfunction

	// Resolution is taken at start; a change lands on the next conversion
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			cnt_q    <= {`CONV_CNT_W{1'b0}};
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (busy_out) begin
				if (cnt_q == {`CONV_CNT_W{1'b0}}) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end else if (run_in && !done_out) begin
				busy_out <= 1'b1;
				cnt_q    <= conv_cycles(res_in) - 1'b1; // R7
			end
		end
	end
endmodule // conv_timer

// *** design/temp_sensor_config_register.v ***
`include "temp_config_defines.vh"
module temp_sensor_config_register #(
	parameter [`CONV_CNT_W-1:0] CONV_9_CYC  = `CONV_9_MS  * `SYS_CLK_KHZ,
	parameter [`CONV_CNT_W-1:0] CONV_10_CYC = `CONV_10_MS * `SYS_CLK_KHZ,
	parameter [`CONV_CNT_W-1:0] CONV_11_CYC = `CONV_11_MS * `SYS_CLK_KHZ,
	parameter [`CONV_CNT_W-1:0] CONV_12_CYC = `CONV_12_MS * `SYS_CLK_KHZ
) (
	input  wire        sys_clk_in,
	input  wire        resetn_in,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe_out,
	input  wire [2:0]  address_select_pins_in,
	input  wire [7:0]  nv_config_in,
	input  wire        register_lock_bit_in,
	input  wire        permanent_lockdown_bit_in,
	input  wire        nonvol_busy_flag_in,
	input  wire        copy_cmd_in,
	input  wire        limit_fault_in,
	input  wire        alert_clear_in,
	output reg  [7:0]  nv_config_store_out,
	output reg         nv_copy_strobe_out,
	output reg  [15:0] config_read_out,
	output wire        conversion_active_out,
	output wire        temp_update_out,
	output reg         shutdown_out,
	output reg  [1:0]  resolution_sel_out,
	output reg         alert_out
);
	// ****************************************
	// Bus receiver states
	// ****************************************
	localparam [2:0] ST_IDLE     = 3'b000;
	localparam [2:0] ST_ADDR     = 3'b001;
	localparam [2:0] ST_ADDR_ACK = 3'b010;
	localparam [2:0] ST_PTR      = 3'b011;
	localparam [2:0] ST_PTR_ACK  = 3'b100;
	localparam [2:0] ST_DATA     = 3'b101;
	localparam [2:0] ST_DATA_ACK = 3'b110;
	localparam [2:0] ST_SKIP     = 3'b111;

	reg  [2:0]              state_q;
	reg  [2:0]              bit_cnt_q;
	reg  [6:0]              shift_q;
	reg                     ack_on_q;
	reg                     ptr_cfg_q;
	reg                     scl_p_q;
	reg                     sda_p_q;
	reg  [7:0]              cfg_q;
	reg                     boot_q;
	reg  [`FAULT_CNT_W-1:0] fault_cnt_q;
	reg                     alarm_p_q;
	reg                     int_latch_q;
	wire [4:0]              sync_w;
	wire                    scl_s;
	wire                    sda_s;
	wire [2:0]              addr_s;
	wire                    start_w;
	wire                    stop_w;
	wire                    scl_rise;
	wire                    scl_fall;
	wire [7:0]              byte_w;
	wire                    byte_done;
	wire                    data_done;
	wire                    accept_w;
	wire                    conv_done;
	wire                    conv_busy;
	wire                    alarm_w;
	wire                    alert_act;

	function [`FAULT_CNT_W-1:0] faults_needed;
		input [1:0] ft;
		begin
			case (ft)
				2'h0:    faults_needed = `FQ_1;
				2'h1:    faults_needed = `FQ_2;
				2'h2:    faults_needed = `FQ_4;
				default: faults_needed = `FQ_6;
			endcase
		end
	endfunction

	// ****************************************
	// Pin synchronisers and bus events
	// ****************************************
	pin_sync #(
		.WIDTH (5)
	) u_sync (
		.sys_clk_in (sys_clk_in),
		.resetn_in  (resetn_in),
		.async_in   ({address_select_pins_in, scl_in, sda_in}),
		.sync_out   (sync_w)
	);

	assign addr_s   = sync_w[4:2];
	assign scl_s    = sync_w[1];
	assign sda_s    = sync_w[0];
	assign start_w  = scl_p_q & scl_s & sda_p_q & ~sda_s;
	assign stop_w   = scl_p_q & scl_s & ~sda_p_q & sda_s;
	assign scl_rise = ~scl_p_q & scl_s;
	assign scl_fall = scl_p_q & ~scl_s;
	assign byte_w   = {shift_q, sda_s};
	assign byte_done = scl_rise && (bit_cnt_q == `BIT_LAST) && !start_w && !stop_w &&
		(state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_DATA);
	assign data_done = byte_done && (state_q == ST_DATA);
	assign accept_w  = data_done && !register_lock_bit_in && !permanent_lockdown_bit_in; // R17

	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// ****************************************
	// Write sequence receiver
	// ****************************************
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			state_q    <= ST_IDLE;
			bit_cnt_q  <= 3'h0;
			shift_q    <= 7'h00;
			ack_on_q   <= 1'b0;
			ptr_cfg_q  <= 1'b0;
			sda_out    <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (start_w) begin
			// Partial byte dropped on repeated start
			state_q    <= ST_ADDR; // R16
			bit_cnt_q  <= 3'h0;
			ack_on_q   <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (stop_w) begin
			state_q    <= ST_IDLE; // R16
			bit_cnt_q  <= 3'h0;
			ack_on_q   <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_PTR, ST_DATA: begin
					if (scl_rise) begin
						shift_q   <= byte_w[6:0];
						bit_cnt_q <= bit_cnt_q + 1'b1;
					end
					if (byte_done) begin
						case (state_q)
							ST_ADDR: begin
								if (byte_w[7:4] == `DEV_ADDR_HI && byte_w[3:1] == addr_s && !byte_w[0]) begin
									state_q <= ST_ADDR_ACK; // R14
								end else begin
									state_q <= ST_SKIP;
								end
							end
							ST_PTR: begin
								ptr_cfg_q <= (byte_w == `CFG_PTR); // R14
								state_q   <= ST_PTR_ACK;
							end
							default: begin
								state_q <= ST_DATA_ACK; // R17
							end
						endcase
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_DATA_ACK: begin
					if (scl_fall) begin
						if (!ack_on_q) begin
							ack_on_q   <= 1'b1;
							sda_oe_out <= 1'b1;
						end else begin
							ack_on_q   <= 1'b0;
							sda_oe_out <= 1'b0;
							bit_cnt_q  <= 3'h0;
							case (state_q)
								ST_ADDR_ACK: state_q <= ST_PTR;
								ST_PTR_ACK:  state_q <= ptr_cfg_q ? ST_DATA : ST_SKIP;
								default:     state_q <= ST_SKIP; // R15
							endcase
						end
					end
				end
				default: begin
					sda_oe_out <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Configuration byte
	// ****************************************
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			// Nonvolatile byte has no one-shot, so that bit starts clear
			cfg_q  <= {1'b0, nv_config_in[6:0]}; // R2
			boot_q <= 1'b1;
		end else begin
			if (conv_done) begin
				boot_q <= 1'b0;
			end
			if (accept_w) begin
				// One-shot only sticks when the written byte asks for shutdown
				cfg_q <= {byte_w[`OS_POS] & byte_w[`SD_POS], byte_w[6:0]}; // R19 R5
			end else if (conv_done && cfg_q[`OS_POS]) begin
				cfg_q[`OS_POS] <= 1'b0; // R4
			end
		end
	end

	// ****************************************
	// Conversion timing
	// ****************************************
	// Power-up in shutdown still yields one valid reading
	conv_timer #(
		.CYC_9  (CONV_9_CYC),
		.CYC_10 (CONV_10_CYC),
		.CYC_11 (CONV_11_CYC),
		.CYC_12 (CONV_12_CYC)
	) u_conv (
		.sys_clk_in (sys_clk_in),
		.resetn_in  (resetn_in),
		.run_in     (!cfg_q[`SD_POS] || cfg_q[`OS_POS] || boot_q), // R11 R4
		.res_in     (cfg_q[`RES_HI:`RES_LO]), // R6
		.busy_out   (conv_busy),
		.done_out   (conv_done)
	);

	assign conversion_active_out = conv_busy;
	assign temp_update_out       = conv_done;

	// ****************************************
	// Fault queue and alert pin
	// ****************************************
	assign alarm_w   = fault_cnt_q >= faults_needed(cfg_q[`FT_HI:`FT_LO]); // R8
	assign alert_act = cfg_q[`MODE_POS] ? int_latch_q : alarm_w; // R10

	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			fault_cnt_q <= {`FAULT_CNT_W{1'b0}};
			alarm_p_q   <= 1'b0;
			int_latch_q <= 1'b0;
			alert_out   <= 1'b1;
		end else begin
			if (accept_w) begin
				fault_cnt_q <= {`FAULT_CNT_W{1'b0}}; // R18
			end else if (conv_done) begin
				if (!limit_fault_in) begin
					fault_cnt_q <= {`FAULT_CNT_W{1'b0}};
				end else if (fault_cnt_q != `FQ_6) begin
					fault_cnt_q <= fault_cnt_q + 1'b1;
				end
			end
			alarm_p_q <= alarm_w;
			// New alarm edge wins over a clear in the same cycle
			// Armed only in interrupt mode; a config write drops a stale request
			if (alarm_w && !alarm_p_q && cfg_q[`MODE_POS]) begin
				int_latch_q <= 1'b1; // R10
			end else if (alert_clear_in || accept_w) begin
				int_latch_q <= 1'b0;
			end
			alert_out <= cfg_q[`POL_POS] ? alert_act : ~alert_act; // R9
		end
	end

	// ****************************************
	// Readback and nonvolatile copy
	// ****************************************
	always @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			config_read_out     <= 16'h0000;
			nv_config_store_out <= 8'h00;
			nv_copy_strobe_out  <= 1'b0;
			shutdown_out        <= 1'b0;
			resolution_sel_out  <= 2'h0;
		end else begin
			config_read_out    <= {1'b0, cfg_q[6:0], `RSVD_VAL, nonvol_busy_flag_in}; // R1 R5 R12 R13
			shutdown_out       <= cfg_q[`SD_POS];
			resolution_sel_out <= cfg_q[`RES_HI:`RES_LO];
			// Copy is refused while the nonvolatile cells are busy
			nv_copy_strobe_out <= copy_cmd_in && !nonvol_busy_flag_in; // R3
			if (copy_cmd_in && !nonvol_busy_flag_in) begin
				nv_config_store_out <= {1'b0, cfg_q[6:0]}; // R3
			end
		end
	end
endmodule // temp_sensor_config_register

// *** sim/cfg_reg_properties.sv ***
module cfg_reg_properties (
	input wire logic        sys_clk_in,
	input wire logic        resetn_in,
	input wire logic        copy_cmd_in,
	input wire logic        nonvol_busy_flag_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_out,
	input wire logic [7:0]  nv_config_store_out,
	input wire logic        nv_copy_strobe_out,
	input wire logic [15:0] config_read_out,
	input wire logic        conversion_active_out,
	input wire logic        temp_update_out,
	input wire logic        shutdown_out,
	input wire logic [1:0]  resolution_sel_out
);
	// ****************************************
	// Sequences and properties
	// ****************************************
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence copy_req;
		copy_cmd_in && !nonvol_busy_flag_in;
	endsequence
	// Eight idle cycles keep a zero-length conversion from passing
	sequence conv_run;
		$rose(conversion_active_out) ##1 !temp_update_out [*8];
	endsequence
	// Ack pulls low from one bus clock fall to the next, at least 8 clocks
	sequence ack_hold;
		(sda_oe_out && !sda_out) [*8];
	endsequence
	copy_strobe_a: assert property (copy_req |=> nv_copy_strobe_out)
		else $error("copy strobe missing");
	strobe_cause_a: assert property (nv_copy_strobe_out |-> $past(copy_cmd_in) && !$past(nonvol_busy_flag_in))
		else $error("copy strobe without request");
	store_byte_a: assert property (nv_copy_strobe_out |-> nv_config_store_out == {1'b0, config_read_out[14:8]})
		else $error("stored byte differs");
	os_zero_a: assert property (config_read_out[15] == 1'b0)
		else $error("one-shot bit read as one");
	rsvd_zero_a: assert property (config_read_out[7:1] == 7'h00)
		else $error("reserved bits not zero");
	busy_mirror_a: assert property ($past(resetn_in) |-> config_read_out[0] == $past(nonvol_busy_flag_in))
		else $error("busy flag wrong");
	field_mirror_a: assert property ($past(resetn_in) |->
		{shutdown_out, resolution_sel_out} == {config_read_out[8], config_read_out[14:13]})
		else $error("field outputs differ");
	conv_done_a: assert property (conv_run |-> ##[1:200] temp_update_out ##1 !temp_update_out)
		else $error("conversion end missing");
	ack_low_a: assert property ($rose(sda_oe_out) |-> ack_hold)
		else $error("data pin driven high");
endmodule // cfg_reg_properties

bind temp_sensor_config_register cfg_reg_properties u_props (.sys_clk_in, .resetn_in, .copy_cmd_in,
	.nonvol_busy_flag_in, .sda_out, .sda_oe_out, .nv_config_store_out, .nv_copy_strobe_out,
	.config_read_out, .conversion_active_out, .temp_update_out, .shutdown_out, .resolution_sel_out);

// *** sim/bus_master_model.sv ***
module bus_master_model (
	input wire logic sys_clk_in,
	input wire logic sda_in,
	output logic     scl_out,
	output logic     sda_low_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Two-wire master, half periods of 4 clocks
	// ****************************************
	initial scl_out = 1;
	initial sda_low_out = 0;
	task automatic tick();
		repeat (4) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic start();
		sda_low_out = 0;
		tick();
		scl_out = 1;
		tick();
		sda_low_out = 1;
		tick();
		scl_out = 0;
	endtask
	task automatic stop();
		sda_low_out = 1;
		tick();
		scl_out = 1;
		tick();
		sda_low_out = 0;
		tick();
	endtask
	// Short byte is cut without an acknowledge phase
	task automatic send(logic [7:0] d, int n, output logic ack);
		ack = 0;
		for (int i = 7; i > 7 - n; i--) begin
			sda_low_out = !d[i];
			tick();
			scl_out = 1;
			tick();
			scl_out = 0;
		end
		if (n == 8) begin
			sda_low_out = 0;
			tick();
			scl_out = 1;
			tick();
			ack = !sda_in;
			scl_out = 0;
		end
	endtask
endmodule // bus_master_model

// *** sim/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, rstn = 0, lock = 0, dn = 0, busy = 0, copy = 0, flt = 0, clr = 0;
	logic       scl, sda_low, sda_o, oe, strobe, act, upd, sd, alert;
	logic [2:0] pins = 3'h5;
	logic [7:0] nv = 8'h00, store, d, ad;
	logic [1:0] res;
	logic [15:0] rd;
	logic [3:0] ak;
	int         seed = 40, error_cnt = 0, n_checks = 0, cfg, nupd = 0, s, k;
	int         need[4] = '{1, 2, 4, 6};
	// Conversion cycles of the overrides plus two restart cycles
	int         per[4] = '{42, 52, 62, 72};
	wire logic  sda = !((oe & !sda_o) | sda_low);
	initial forever #25 clk = ~clk;
	always @(negedge clk) if (upd === 1'b1) nupd++;
	bus_master_model m (.sys_clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
	temp_sensor_config_register #(.CONV_9_CYC(22'h28), .CONV_10_CYC(22'h32), .CONV_11_CYC(22'h3C),
		.CONV_12_CYC(22'h46)) u_dut (.sys_clk_in(clk), .resetn_in(rstn), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(oe), .address_select_pins_in(pins), .nv_config_in(nv),
		.register_lock_bit_in(lock), .permanent_lockdown_bit_in(dn), .nonvol_busy_flag_in(busy),
		.copy_cmd_in(copy), .limit_fault_in(flt), .alert_clear_in(clr), .nv_config_store_out(store),
		.nv_copy_strobe_out(strobe), .config_read_out(rd), .conversion_active_out(act),
		.temp_update_out(upd), .shutdown_out(sd), .resolution_sel_out(res), .alert_out(alert));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic close_out();
		if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(logic [15:0] g, logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic wu();
		int b;
		b = nupd;
		for (int i = 0; i < 400 && nupd == b; i++) step();
		if (nupd == b) begin
			error_cnt++;
			close_out();
		end
	endtask
	task automatic xfer(logic [7:0] a, logic [7:0] v, int nb, int x2);
		ak = 4'h0;
		m.start();
		m.send(a, 8, ak[3]);
		m.send(8'h01, 8, ak[2]);
		m.send(v, nb, ak[1]);
		// Mode 1 adds a second data byte, mode 2 a repeated start
		if (x2 == 1) m.send(~v, 8, ak[0]);
		if (x2 == 2) m.start();
		m.stop();
		repeat (2) step();
	endtask
	function automatic logic [15:0] expv();
		return {1'b0, cfg[6:0], 7'h00, busy};
	endfunction
	task automatic rst();
		nv = $random(seed);
		rstn = 0;
		repeat (3) step();
		rstn = 1;
		cfg = nv;
		repeat (4) step();
		chk(rd, expv());
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		rst();
		ad = {4'h9, pins, 1'b0};
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			d[6:5] = i;
			busy = i;
			xfer(ad, d, 8, 0);
			cfg = d;
			chk(ak, 4'hE);
			chk(rd, expv());
			chk({sd, res}, {d[0], d[6:5]});
		end
		xfer(ad, 8'h0C, 8, 1);
		cfg = 8'h0C;
		chk(ak, 4'hE);
		chk(rd, expv());
		xfer(ad, 8'h70, 5, 0);
		chk(rd, expv());
		xfer(ad, 8'h70, 5, 2);
		chk(rd, expv());
		xfer(ad ^ 8'h02, 8'h70, 8, 0);
		chk(ak[3], 1'b0);
		chk(rd, expv());
		for (int j = 0; j < 2; j++) begin
			{dn, lock} = 2'h1 << j;
			xfer(ad, 8'h66, 8, 0);
			chk(ak, 4'hE);
			chk(rd, expv());
		end
		{dn, lock} = 2'h0;
		busy = 0;
		copy = 1;
		step();
		copy = 0;
		chk({strobe, store}, {1'b1, 1'b0, cfg[6:0]});
		busy = 1;
		copy = 1;
		step();
		copy = 0;
		busy = 0;
		chk(strobe, 0);
		for (int f = 0; f < 4; f++) begin
			d = {3'h0, f[1:0], f[0], 2'h0};
			xfer(ad, d, 8, 0);
			chk(alert, !d[2]);
			flt = 1;
			for (k = 1; k < 9; k++) begin
				wu();
				repeat (3) step();
				if (alert === d[2]) break;
			end
			chk(k, need[f]);
			flt = 0;
			wu();
			wu();
		end
		for (int r = 0; r < 4; r++) begin
			xfer(ad, {1'b0, r[1:0], 5'h00}, 8, 0);
			wu();
			s = nupd;
			for (k = 0; k < 400 && nupd == s; k++) step();
			chk(k, per[r]);
			if (k == 400) close_out();
		end
		xfer(ad, 8'h02, 8, 0);
		chk(alert, 1);
		flt = 1;
		wu();
		flt = 0;
		wu();
		wu();
		repeat (3) step();
		chk(alert, 0);
		clr = 1;
		step();
		clr = 0;
		repeat (3) step();
		chk(alert, 1);
		xfer(ad, 8'h01, 8, 0);
		repeat (200) step();
		s = nupd;
		repeat (300) step();
		chk(nupd - s, 0);
		s = nupd;
		xfer(ad, 8'h81, 8, 0);
		repeat (300) step();
		cfg = 8'h01;
		chk(nupd - s, 1);
		chk(rd, expv());
		// One-shot per write; without the clear the second fault would alarm
		flt = 1;
		for (int j = 0; j < 2; j++) begin
			xfer(ad, 8'h89, 8, 0);
			wu();
		end
		repeat (3) step();
		chk(alert, 1);
		flt = 0;
		rst();
		close_out();
	end
endmodule // testbench
